// File: fdec_regs.vh
// Register offsets, flag and status bit positions, codes and reset values of the floating-point decoder
`ifndef FDEC_REGS_VH
`define FDEC_REGS_VH
// Register offsets (byte addresses)
`define FD_FLAGS      8'h00
`define FD_INSTR      8'h04
`define FD_STATUS     8'h08
`define FD_ACC_MAIN   8'h0c
`define FD_ACC_DBL    8'h10
`define FD_SAVE_MAIN  8'h14
`define FD_SAVE_DBL   8'h18
`define FD_INDEX_BASE 8'h20
// Flag bit positions
`define FLG_UNC 0
`define FLG_Z   1
`define FLG_G   2
`define FLG_L   3
`define FLG_C   4
`define FLG_V   5
`define FLG_B   6
`define FLG_E   7
`define FLG_P1  8
// Status bit positions
`define ST_BUSY   0
`define ST_COMPAT 1
`define ST_ILL    2
`define ST_COND   3
// Reset values
`define FLAGS_RST 16'h0001
// Instruction class codes
`define CLS_FLOAT 4'h4
`define CLS_HALF  4'h7
`define CLS_TEST  4'hf
// Operation codes
`define OP_SUB   4'h0
`define OP_CSUB  4'h1
`define OP_CADD  4'h2
`define OP_ADD   4'h3
`define OP_CMP   4'h4
`define OP_MUL   4'h5
`define OP_ST    4'h6
`define OP_SR    4'h7
`define OP_DIV   4'h8
`define OP_CDIV  4'h9
// Halfword select codes
`define W_IMM   2'b00
`define W_LEFT  2'b01
`define W_RIGHT 2'b10
`endif

// File: float_instruction_decode.v
// Floating-point instruction decoder and executor with address resolution and flag register
`timescale 1ns/10ps
`default_nettype none
`include "fdec_regs.vh"

module float_instruction_decode #(
	parameter NIDX = 7                 // Number of index registers
) (
	input  wire        clk_i,          // Clock, 200 MHz
	input  wire        rst_i,          // Asynchronous reset, active high
	input  wire [7:0]  reg_addr_i,     // Register byte address
	input  wire [31:0] reg_wdata_i,    // Register write data
	input  wire        reg_wr_i,       // Register write strobe
	input  wire        reg_rd_i,       // Register read strobe
	output reg  [31:0] reg_rdata_o,    // Register read data, cycle after strobe
	output reg         mem_req_o,      // Core memory request
	output reg         mem_we_o,       // Core memory write
	output reg  [15:0] mem_addr_o,     // Core memory word address
	output reg  [31:0] mem_wdata_o,    // Core memory write data
	input  wire [31:0] mem_rdata_i,    // Core memory read data, valid with ack
	input  wire        mem_ack_i,      // Core memory access done
	input  wire        chan_busy_i,    // Data channel busy pin
	output reg         busy_o,         // Instruction in progress
	output reg         compat_req_o,   // Compatibility subroutine call pulse
	output reg  [31:0] compat_instr_o, // Instruction handed to the subroutine
	output reg  [15:0] flags_o         // Flag register
);

	// ****************************************
	// State and storage
	// ****************************************
	localparam [7:0] S_IDLE = 8'h01;
	localparam [7:0] S_DEC  = 8'h02;
	localparam [7:0] S_IND  = 8'h04;
	localparam [7:0] S_OPR  = 8'h08;
	localparam [7:0] S_OPR2 = 8'h10;
	localparam [7:0] S_EXEC = 8'h20;
	localparam [7:0] S_STW  = 8'h40;
	localparam [7:0] S_STW2 = 8'h80;

	reg  [7:0]  state_q;
	reg  [7:0]  state_d;
	reg  [31:0] ir_q;
	reg  [15:0] ea_q;
	reg  [15:0] ea_d;
	reg  [63:0] opnd_q;
	reg  [15:0] a_q;
	reg  [15:0] af_q;
	reg  [15:0] ad_q;
	reg  [47:0] sv_q;
	reg  [15:0] xr_q [1:NIDX];
	reg  [15:0] flags_q;
	reg  [3:0]  stat_q;
	reg         bsy_s1_q;
	reg         bsy_s2_q;
	integer     k;

	// ****************************************
	// Instruction fields
	// ****************************************
	wire [15:0] adr_f   = ir_q[31:16];
	wire        ind_f   = ir_q[15];
	wire [2:0]  xsel    = ir_q[14:12];
	wire [3:0]  cls     = ir_q[11:8];
	wire        mod_u   = ir_q[7];
	wire [1:0]  wsel    = ir_q[6:5];
	wire        mod_sv  = ir_q[4];
	wire [3:0]  op      = ir_q[3:0];
	wire [15:0] idx_w   = (xsel == 3'h0) ? 16'h0 : xr_q[xsel];
	wire        is_flt  = (cls == `CLS_FLOAT) && !wsel[0];
	wire        is_dbl  = is_flt && wsel[1];
	wire        is_half = (cls == `CLS_HALF) && mod_u;
	wire        is_test = (cls == `CLS_TEST);
	wire        is_st   = (op == `OP_ST) || (op == `OP_SR);
	wire        is_imm  = is_half && (wsel == `W_IMM);
	wire        is_cmpt = is_dbl && (op == `OP_MUL || op == `OP_DIV || op == `OP_CDIV ||
		op == `OP_CMP || op == `OP_SR);
	wire        bad_h   = (wsel == 2'b11) || (is_imm && is_st) ||
		(op != `OP_CADD && op != `OP_ST);
	wire        illegal = !(is_flt || is_half || is_test) || (is_flt && op > `OP_CDIV) ||
		(is_half && bad_h);
	wire        skip_op = is_imm || (is_flt && is_st);
	wire [7:0]  nxt_ea  = skip_op ? S_EXEC : S_OPR;
	wire        wr_ok   = reg_wr_i && state_q[0];
	wire        sel_x   = (reg_addr_i[7:5] == `FD_INDEX_BASE >> 5) && (reg_addr_i[1:0] == 2'b00) &&
		(reg_addr_i[4:2] != 3'h0);
	wire        t_flag  = flags_q[op] ^ mod_u;

	// ****************************************
	// Normalisation
	// ****************************************
	function [47:0] norm48;
		input [47:0] v;
		integer i;
		reg [47:0] t;
		begin
			t = v;
			for (i = 0; i < 47; i = i + 1) begin
				if (t != 48'h0 && t[47] == t[46])
					t = {t[46:0], 1'b0};
			end
			norm48 = t;
		end
	endfunction

	// ****************************************
	// Execute
	// ****************************************
	reg [47:0] x_acc;
	reg [47:0] x_key;
	reg [47:0] mx;
	reg [48:0] sum49;
	reg [48:0] dif49;
	reg [48:0] neg49;
	reg [63:0] prod;
	reg [47:0] dvd;
	reg [47:0] dvs;
	reg [47:0] quo;
	reg [47:0] rem;
	reg [32:0] rnd33;
	reg [31:0] x_wr0;
	reg [31:0] x_wr1;
	reg [15:0] hop;
	reg        x_cy;
	reg        x_v;
	reg        x_zgl;
	reg        x_z;
	reg        x_g;
	reg        x_l;

	always @* begin
		mx    = is_dbl ? opnd_q[63:16] : {opnd_q[63:32], 16'h0};
		sum49 = {1'b0, a_q, af_q, ad_q} + {1'b0, mx};
		dif49 = {1'b0, a_q, af_q, ad_q} - {1'b0, mx};
		neg49 = 49'h0 - {1'b0, mx};
		prod  = $signed({a_q, af_q}) * $signed(opnd_q[63:32]);
		dvd   = (op == `OP_CDIV) ? {a_q, af_q, 16'h0} : {a_q, af_q, ad_q};
		dvs   = {{16{opnd_q[63]}}, opnd_q[63:32]};
		quo   = (dvs == 48'h0) ? 48'h0 : $signed(dvd) / $signed(dvs);
		rem   = (dvs == 48'h0) ? 48'h0 : $signed(dvd) % $signed(dvs);
		rnd33 = {1'b0, a_q, af_q} + {32'h0, ad_q[15]};
		hop   = is_imm ? ea_q : ((wsel == `W_RIGHT) ? opnd_q[47:32] : opnd_q[63:48]);
		x_acc = {a_q, af_q, ad_q};
		x_key = 48'h0;
		x_wr0 = {a_q, af_q};
		x_wr1 = {ad_q, 16'h0};
		x_cy  = 1'b0;
		x_v   = 1'b0;
		x_zgl = 1'b0;
		x_z   = 1'b0;
		x_g   = 1'b0;
		x_l   = 1'b0;
		if (is_half) begin
			x_zgl = (op == `OP_CADD);
			x_key = {hop, 32'h0};
			if (op == `OP_CADD)
				x_acc = {hop, af_q, ad_q};
			x_wr0 = (wsel == `W_RIGHT) ? {opnd_q[63:48], a_q} : {a_q, opnd_q[47:32]};
		end else begin
			case (op)
				`OP_ADD, `OP_SUB, `OP_CADD, `OP_CSUB: begin
					x_zgl = 1'b1;
					case (op)
						`OP_ADD:  x_acc = sum49[47:0];
						`OP_SUB:  x_acc = dif49[47:0];
						`OP_CADD: x_acc = mx;
						default:  x_acc = neg49[47:0];
					endcase
					if (op == `OP_ADD)
						x_cy = sum49[48];
					if (op == `OP_SUB)
						x_cy = !dif49[48];
					if (!is_dbl)
						x_acc[15:0] = 16'h0;
					if (!mod_u)
						x_acc = norm48(x_acc);
					if (!is_dbl)
						x_acc[15:0] = ad_q;
					x_key = is_dbl ? x_acc : {x_acc[47:16], 16'h0};
				end
				`OP_MUL: begin
					x_zgl = 1'b1;
					x_acc = mod_u ? prod[63:16] : norm48(prod[63:16]);
					x_key = x_acc;
				end
				`OP_DIV, `OP_CDIV: begin
					x_zgl = 1'b1;
					x_v   = (dvs == 48'h0) || (quo[47:31] != {17{quo[31]}});
					if (!x_v)
						x_acc = {quo[31:0], rem[15:0]};
					x_key = {x_acc[47:16], 16'h0};
				end
				`OP_CMP: begin
					x_z = ({a_q, af_q} == opnd_q[63:32]);
					x_g = ($signed({a_q, af_q}) > $signed(opnd_q[63:32]));
					x_l = !x_z && !x_g;
				end
				`OP_SR: begin
					x_wr0 = rnd33[31:0];
					x_cy  = rnd33[32];
				end
				default: begin
					x_wr0 = {a_q, af_q};
				end
			endcase
		end
		if (x_zgl) begin
			x_z = (x_key == 48'h0);
			x_l = x_key[47];
			x_g = !x_z && !x_key[47];
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always @* begin
		state_d = state_q;
		ea_d    = ea_q;
		case (state_q)
			S_IDLE: begin
				if (wr_ok && reg_addr_i == `FD_INSTR)
					state_d = S_DEC;
			end
			S_DEC: begin
				ea_d = adr_f + idx_w;
				if (illegal || is_cmpt)
					state_d = S_IDLE;
				else if (is_test)
					state_d = S_EXEC;
				else if (ind_f)
					state_d = S_IND;
				else
					state_d = nxt_ea;
			end
			S_IND: begin
				if (mem_ack_i) begin
					ea_d = mem_rdata_i[31:16] + idx_w;
					if (!mem_rdata_i[15])
						state_d = nxt_ea;
				end
			end
			S_OPR: begin
				if (mem_ack_i)
					state_d = is_dbl ? S_OPR2 : S_EXEC;
			end
			S_OPR2: begin
				if (mem_ack_i)
					state_d = S_EXEC;
			end
			S_EXEC: begin
				state_d = (is_st && !is_test) ? S_STW : S_IDLE;
			end
			S_STW: begin
				if (mem_ack_i)
					state_d = is_dbl ? S_STW2 : S_IDLE;
			end
			S_STW2: begin
				if (mem_ack_i)
					state_d = S_IDLE;
			end
			default: state_d = S_IDLE;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q        <= S_IDLE;
			ir_q           <= 32'h0;
			ea_q           <= 16'h0;
			opnd_q         <= 64'h0;
			a_q            <= 16'h0;
			af_q           <= 16'h0;
			ad_q           <= 16'h0;
			sv_q           <= 48'h0;
			flags_q        <= `FLAGS_RST;
			stat_q         <= 4'h0;
			bsy_s1_q       <= 1'b0;
			bsy_s2_q       <= 1'b0;
			reg_rdata_o    <= 32'h0;
			mem_req_o      <= 1'b0;
			mem_we_o       <= 1'b0;
			mem_addr_o     <= 16'h0;
			mem_wdata_o    <= 32'h0;
			busy_o         <= 1'b0;
			compat_req_o   <= 1'b0;
			compat_instr_o <= 32'h0;
			flags_o        <= `FLAGS_RST;
			for (k = 1; k <= NIDX; k = k + 1)
				xr_q[k] <= 16'h0;
		end else begin
			bsy_s1_q     <= chan_busy_i;
			bsy_s2_q     <= bsy_s1_q;
			state_q      <= state_d;
			ea_q         <= ea_d;
			busy_o       <= (state_d != S_IDLE);
			compat_req_o <= 1'b0;
			mem_req_o    <= |(state_d & (S_IND | S_OPR | S_OPR2 | S_STW | S_STW2));
			mem_we_o     <= |(state_d & (S_STW | S_STW2));
			mem_addr_o   <= (|(state_d & (S_OPR2 | S_STW2))) ? ea_d + 16'h1 : ea_d;
			mem_wdata_o  <= (state_d == S_STW2) ? x_wr1 : x_wr0;
			flags_o      <= flags_q;

			// Software writes, refused while an instruction runs, except the status clear below
			if (wr_ok) begin
				case (reg_addr_i)
					`FD_INSTR:    ir_q <= reg_wdata_i;
					`FD_FLAGS:    flags_q[15:7] <= reg_wdata_i[15:7];
					`FD_ACC_MAIN: {a_q, af_q} <= reg_wdata_i;
					`FD_ACC_DBL:  ad_q <= reg_wdata_i[15:0];
					default: begin
						if (sel_x)
							xr_q[reg_addr_i[4:2]] <= reg_wdata_i[15:0];
					end
				endcase
				if (reg_addr_i == `FD_FLAGS)
					flags_q[5:1] <= reg_wdata_i[5:1];
			end
			if (reg_wr_i && reg_addr_i == `FD_STATUS)
				stat_q[3:1] <= stat_q[3:1] & ~reg_wdata_i[3:1];
			flags_q[`FLG_UNC] <= 1'b1;
			flags_q[`FLG_B]   <= bsy_s2_q;

			if (state_q == S_DEC) begin
				if (illegal)
					stat_q[`ST_ILL] <= 1'b1;
				else if (is_cmpt) begin
					stat_q[`ST_COMPAT] <= 1'b1;
					compat_req_o       <= 1'b1;
					compat_instr_o     <= ir_q;
				end
			end
			if (mem_ack_i && state_q == S_OPR)
				opnd_q[63:32] <= mem_rdata_i;
			if (mem_ack_i && state_q == S_OPR2)
				opnd_q[31:0] <= mem_rdata_i;

			if (state_q == S_EXEC) begin
				if (is_test) begin
					stat_q[`ST_COND] <= t_flag;
					if (t_flag && op != `FLG_UNC && op != `FLG_B)
						flags_q[op] <= 1'b0;
				end else begin
					if (mod_sv)
						sv_q <= {a_q, af_q, ad_q};
					{a_q, af_q, ad_q} <= x_acc;
					flags_q[`FLG_Z] <= x_z;
					flags_q[`FLG_G] <= x_g;
					flags_q[`FLG_L] <= x_l;
					flags_q[`FLG_C] <= x_cy;
					if (x_v)
						flags_q[`FLG_V] <= 1'b1;
				end
			end

			// Register reads
			reg_rdata_o <= 32'h0;
			if (reg_rd_i) begin
				case (reg_addr_i)
					`FD_FLAGS:     reg_rdata_o <= {16'h0, flags_q};
					`FD_INSTR:     reg_rdata_o <= ir_q;
					`FD_STATUS:    reg_rdata_o <= {28'h0, stat_q[3:1], busy_o};
					`FD_ACC_MAIN:  reg_rdata_o <= {a_q, af_q};
					`FD_ACC_DBL:   reg_rdata_o <= {16'h0, ad_q};
					`FD_SAVE_MAIN: reg_rdata_o <= sv_q[47:16];
					`FD_SAVE_DBL:  reg_rdata_o <= {16'h0, sv_q[15:0]};
					default: begin
						if (sel_x)
							reg_rdata_o <= {16'h0, xr_q[reg_addr_i[4:2]]};
					end
				endcase
			end
		end
	end

endmodule // float_instruction_decode
`default_nettype wire

// File: fdec_monitor.sv
// Port checker for the floating-point decoder
`timescale 1ns/10ps
`default_nettype none
`include "fdec_regs.vh"
module fdec_monitor (
	input wire logic        clk_i,        // Clock
	input wire logic        rst_i,        // Reset
	input wire logic [7:0]  reg_addr_i,   // Reg address
	input wire logic        reg_wr_i,     // Write strobe
	input wire logic        reg_rd_i,     // Read strobe
	input wire logic [31:0] reg_rdata_o,  // Read data
	input wire logic        mem_req_o,    // Mem request
	input wire logic        mem_we_o,     // Mem write
	input wire logic [15:0] mem_addr_o,   // Mem address
	input wire logic        mem_ack_i,    // Mem ack
	input wire logic        chan_busy_i,  // Busy pin
	input wire logic        busy_o,       // Running
	input wire logic        compat_req_o, // Subroutine call
	input wire logic [15:0] flags_o       // Flags
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_unc; flags_o[0]; endproperty
	a_unc: assert property (p_unc) else $error("flag0 low");
	property p_zgl; $onehot0(flags_o[3:1]); endproperty
	a_zgl: assert property (p_zgl) else $error("zgl clash");
	property p_cpulse; compat_req_o |=> !compat_req_o; endproperty
	a_cpulse: assert property (p_cpulse) else $error("call too long");
	property p_cquiet; compat_req_o |-> !mem_req_o && !busy_o; endproperty
	a_cquiet: assert property (p_cquiet) else $error("call with access");
	property p_cstart; compat_req_o |-> $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == `FD_INSTR; endproperty
	a_cstart: assert property (p_cstart) else $error("call timing");
	property p_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o); endproperty
	a_hold: assert property (p_hold) else $error("access dropped");
	property p_we; mem_we_o |-> mem_req_o; endproperty
	a_we: assert property (p_we) else $error("write alone");
	property p_bpin; $rose(chan_busy_i) |-> ##[2:5] flags_o[6]; endproperty
	a_bpin: assert property (p_bpin) else $error("busy flag late");
	property p_rd0; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("stray read data");
	c_compat: cover property (compat_req_o);
	c_store: cover property (mem_we_o && mem_ack_i);
	c_ovf: cover property ($rose(flags_o[5]));
endmodule // fdec_monitor
bind float_instruction_decode fdec_monitor u_mon (.clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_ack_i, .chan_busy_i, .busy_o,
	.compat_req_o, .flags_o);
`default_nettype wire

// File: core_mem_model.sv
// Core memory partner answering the decoder's requests
`timescale 1ns/10ps
`default_nettype none
module core_mem_model (
	input wire logic        clk_i,   // Clock
	input wire logic        rst_i,   // Reset
	input wire logic        req_i,   // Request
	input wire logic        we_i,    // Write
	input wire logic        slow_i,  // Add wait states
	input wire logic [15:0] addr_i,  // Word address
	input wire logic [31:0] wdata_i, // Write data
	output logic     [31:0] rdata_o, // Read data
	output logic            ack_o    // Access done
);
	logic [31:0] mem [0:255];
	logic [1:0]  wait_q;
	// Read data toggles outside the ack cycle
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o   <= 1'b0;
			wait_q  <= 2'h0;
			rdata_o <= 32'h0;
		end else if (req_i && !ack_o && (!slow_i || wait_q == 2'h3)) begin
			ack_o   <= 1'b1;
			wait_q  <= 2'h0;
			rdata_o <= mem[addr_i[7:0]];
			if (we_i)
				mem[addr_i[7:0]] <= wdata_i;
		end else begin
			ack_o   <= 1'b0;
			wait_q  <= req_i ? wait_q + 2'h1 : 2'h0;
			rdata_o <= ~rdata_o;
		end
	end
endmodule // core_mem_model
`default_nettype wire

// File: float_instruction_decode_tb_top.sv
// Self-checking bench for the floating-point decoder
`timescale 1ns/10ps
`default_nettype none
`include "fdec_regs.vh"
module float_instruction_decode_tb_top;
	logic        clk_i, rst_i, reg_wr_i, reg_rd_i, mem_req_o, mem_we_o, mem_ack_i;
	logic        chan_busy_i, busy_o, compat_req_o, cq, slow;
	logic [7:0]  reg_addr_i;
	logic [15:0] mem_addr_o, flags_o;
	logic [31:0] reg_wdata_i, reg_rdata_o, mem_wdata_o, mem_rdata_i, compat_instr_o, ci, d, a, m, e;
	logic [3:0]  hw [3] = '{4'ha, 4'hc, 4'h8};
	logic [15:0] hx [3] = '{16'h1234, 16'h5678, 16'h0065};
	logic [3:0]  cops [5] = '{`OP_MUL, `OP_DIV, `OP_CDIV, `OP_CMP, `OP_SR};
	int          fails, tests_run, i, n;
	float_instruction_decode DUT (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i,
		.chan_busy_i, .busy_o, .compat_req_o, .compat_instr_o, .flags_o);
	core_mem_model u_mem (.clk_i, .rst_i, .req_i(mem_req_o), .we_i(mem_we_o), .slow_i(slow),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
	function automatic logic [31:0] ins(input logic [15:0] ad, input logic [3:0] ix, cl, uw, op);
		return {ad, ix, cl, uw, op};
	endfunction
	task automatic final_report;
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] v);
		reg_addr_i  <= ad;
		reg_wdata_i <= v;
		reg_wr_i    <= 1'b1;
		@(posedge clk_i);
		reg_wr_i    <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] ad);
		reg_addr_i <= ad;
		reg_rd_i   <= 1'b1;
		@(posedge clk_i);
		reg_rd_i   <= 1'b0;
		@(negedge clk_i);
		d = reg_rdata_o;
		@(posedge clk_i);
	endtask
	task automatic rc(input logic [7:0] ad, input logic [31:0] v);
		rd(ad);
		chk(d, v);
	endtask
	task automatic fl(input logic [31:0] r);
		chk(flags_o[3:1], {r[31], !r[31] && r != 0, r == 0});
	endtask
	task automatic run(input logic [31:0] v);
		wr(`FD_INSTR, v);
		@(negedge clk_i);
		cq = compat_req_o;
		ci = compat_instr_o;
		for (n = 0; busy_o !== 1'b0 && n < 300; n++)
			@(negedge clk_i);
		if (n == 300)
			fails++;
		@(posedge clk_i);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		fails++;
		final_report;
	end
	initial begin
		rst_i = 1'b1;
		{reg_wr_i, reg_rd_i, chan_busy_i, slow} = 4'h0;
		reg_addr_i = 8'h0;
		reg_wdata_i = 32'h0;
		fails = 0;
		tests_run = 0;
		void'($urandom(35986));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(flags_o, 32'h1);
		rc(`FD_FLAGS, 32'h1);
		rc(8'h40, 32'h0);
		u_mem.mem[8'h10] = 32'h1000_0000;
		run(ins(16'h10, 4'h0, `CLS_FLOAT, 4'h0, `OP_CADD));
		rc(`FD_ACC_MAIN, 32'h4000_0000);
		run(ins(16'h10, 4'h0, `CLS_FLOAT, 4'h8, `OP_CADD));
		rc(`FD_ACC_MAIN, 32'h1000_0000);
		for (i = 0; i < 8; i++) begin
			a = $urandom & 32'h3fff_ffff;
			m = $urandom & 32'h3fff_ffff;
			slow <= i[0];
			wr(`FD_ACC_MAIN, a);
			u_mem.mem[8'h20] = m;
			run(ins(16'h20, 4'h0, `CLS_FLOAT, 4'h9, {2'b00, i[1:0]}));
			e = i[1:0] == 2'h3 ? a + m : i[1:0] == 2'h2 ? m : i[1:0] == 2'h0 ? a - m : -m;
			rc(`FD_ACC_MAIN, e);
			rc(`FD_SAVE_MAIN, a);
			fl(e);
		end
		wr(`FD_INDEX_BASE + 8'h04, 32'h5);
		u_mem.mem[8'h35] = 32'h0040_9000;
		u_mem.mem[8'h45] = 32'h0050_1000;
		u_mem.mem[8'h55] = 32'h4321_0000;
		run(ins(16'h30, 4'h9, `CLS_FLOAT, 4'h8, `OP_CADD));
		rc(`FD_ACC_MAIN, 32'h4321_0000);
		u_mem.mem[8'h60] = 32'h1234_5678;
		for (i = 0; i < 3; i++) begin
			run(ins(16'h60, {3'h0, i == 2}, `CLS_HALF, hw[i], `OP_CADD));
			rd(`FD_ACC_MAIN);
			chk(d[31:16], hx[i]);
		end
		run(ins(16'h60, 4'h0, `CLS_HALF, 4'he, `OP_CADD));
		rd(`FD_STATUS);
		chk(d[2], 1'b1);
		wr(`FD_STATUS, 32'he);
		rc(`FD_STATUS, 32'h0);
		run(ins(16'h60, 4'h0, `CLS_HALF, 4'h8, `OP_ST));
		rd(`FD_STATUS);
		chk(d[2], 1'b1);
		chk(u_mem.mem[8'h60], 32'h1234_5678);
		wr(`FD_ACC_MAIN, 32'h2000_0000);
		for (i = 0; i < 3; i++) begin
			u_mem.mem[8'h70] = 32'h1000_0000 * (i + 1);
			run(ins(16'h70, 4'h0, `CLS_FLOAT, 4'h0, `OP_CMP));
			rc(`FD_ACC_MAIN, 32'h2000_0000);
			chk(flags_o[3:1], i == 2 ? 3'b100 : 3'b010 >> i);
		end
		wr(`FD_ACC_MAIN, 32'h1357_9bdf);
		wr(`FD_ACC_DBL, 32'h8000);
		run(ins(16'h80, 4'h0, `CLS_FLOAT, 4'h0, `OP_ST));
		run(ins(16'h81, 4'h0, `CLS_FLOAT, 4'h0, `OP_SR));
		chk(u_mem.mem[8'h80], 32'h1357_9bdf);
		chk(u_mem.mem[8'h81], 32'h1357_9be0);
		for (i = 0; i < 5; i++) begin
			e = ins(16'h90, 4'h0, `CLS_FLOAT, 4'h4, cops[i]);
			run(e);
			chk(cq, 1'b1);
			chk(ci, e);
		end
		u_mem.mem[8'h90] = 32'h4000_0001;
		u_mem.mem[8'h91] = 32'habcd_1234;
		run(ins(16'h90, 4'h0, `CLS_FLOAT, 4'hc, `OP_CADD));
		rc(`FD_ACC_MAIN, 32'h4000_0001);
		rc(`FD_ACC_DBL, 32'habcd);
		run(ins(16'ha0, 4'h0, `CLS_FLOAT, 4'h4, `OP_ST));
		chk(u_mem.mem[8'ha1], 32'habcd_0000);
		wr(`FD_ACC_MAIN, 32'h4000_0000);
		wr(`FD_ACC_DBL, 32'h0);
		u_mem.mem[8'hb8] = 32'h4000_0000;
		run(ins(16'hb8, 4'h0, `CLS_FLOAT, 4'h8, `OP_MUL));
		rc(`FD_ACC_MAIN, 32'h1000_0000);
		rc(`FD_ACC_DBL, 32'h0);
		u_mem.mem[8'hb0] = 32'h0;
		run(ins(16'hb0, 4'h0, `CLS_FLOAT, 4'h0, `OP_DIV));
		run(ins(16'h10, 4'h0, `CLS_FLOAT, 4'h8, `OP_CADD));
		rd(`FD_STATUS);
		chk(flags_o[5], 1'b1);
		run(ins(16'h0, 4'h0, `CLS_TEST, 4'h0, 4'h5));
		rd(`FD_STATUS);
		chk(flags_o[5], 1'b0);
		wr(`FD_FLAGS, 32'h0100);
		rc(`FD_FLAGS, 32'h0101);
		run(ins(16'h0, 4'h0, `CLS_TEST, 4'h8, 4'h8));
		rd(`FD_STATUS);
		chk({d[3], flags_o[8]}, 2'b01);
		run(ins(16'h0, 4'h0, `CLS_TEST, 4'h0, 4'h8));
		rd(`FD_STATUS);
		chk({d[3], flags_o[8]}, 2'b10);
		chan_busy_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk(flags_o[6], 1'b1);
		chan_busy_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		final_report;
	end
endmodule // float_instruction_decode_tb_top
`default_nettype wire
